// ### rtl/sbe_ctrl.sv
/*
  Package and module for the break, edge and receive-flag control of a LIN-capable
  serial interface: receive inversion, active-edge flag, standby idle qualification,
  transmit break generation and LIN break detection with flag suppression.
  Assumes a separate baud generator that gives a one-cycle pulse once per bit time,
  and a receiver core that pulses its framing, full and idle events.
*/
package sbe_pkg;
  localparam int unsigned CNT_W         = 4;
  localparam logic [3:0]  BRK_SHORT_LEN = 4'hA;
  localparam logic [3:0]  BRK_SHORT_M   = 4'hB;
  localparam logic [3:0]  BRK_LONG_LEN  = 4'hD;
  localparam logic [3:0]  BRK_LONG_M    = 4'hE;
  localparam logic [3:0]  LIN_DET_LEN   = 4'hB;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;
  localparam logic        LINE_IDLE     = 1'b1;

  typedef enum logic [1:0] {
    SBE_TX_IDLE = 2'b01,
    SBE_TX_BRK  = 2'b10
  } sbe_tx_e;

  typedef logic [CNT_W-1:0] sbe_cnt_t;

  typedef struct packed {
    logic     rx_prev;
    logic     rx_data;
    logic     rx_edge_flag;
    logic     lin_break_flag;
    sbe_cnt_t low_cnt;
    logic     low_seen;
    sbe_tx_e  tx_state;
    sbe_cnt_t tx_cnt;
    sbe_cnt_t tx_len;
    logic     txd;
    logic     fe_set;
    logic     full_set;
    logic     idle_set;
  } sbe_state_s;
endpackage

`timescale 1ns/10ps

module sbe_ctrl
  import sbe_pkg::*;
(
  input  wire logic CORE_CLK,
  input  wire logic SRST,
  input  wire logic RXD_PIN,
  input  wire logic BIT_TICK,
  input  wire logic RX_INVERT,
  input  wire logic RECEIVER_STANDBY,
  input  wire logic STANDBY_IDLE_FLAG_SELECT,
  input  wire logic LONG_BREAK_SELECT,
  input  wire logic NINE_BIT_SELECT,
  input  wire logic LIN_BREAK_DETECT_ENABLE,
  input  wire logic RX_EDGE_FLAG_WR,
  input  wire logic LIN_BREAK_FLAG_WR,
  input  wire logic FLAG_WR_DATA,
  input  wire logic FRAME_ERR_EVENT,
  input  wire logic RX_FULL_EVENT,
  input  wire logic IDLE_EVENT,
  input  wire logic BREAK_SEND_REQ,
  output logic      RX_DATA,
  output logic      RX_EDGE_FLAG,
  output logic      LIN_BREAK_FLAG,
  output logic      FRAMING_ERROR_SET,
  output logic      RX_FULL_SET,
  output logic      IDLE_SET,
  output logic      TX_LINE,
  output logic      BREAK_BUSY
);
  import sbe_pkg::*;

  sbe_state_s st_reg;
  sbe_state_s st_next;
  logic       rx_in;
  logic       active_edge;
  logic       lin_break_hit;
  sbe_cnt_t   brk_len;

  assign rx_in       = RXD_PIN ^ RX_INVERT;
  assign active_edge = st_reg.rx_prev & ~rx_in;
  assign lin_break_hit = LIN_BREAK_DETECT_ENABLE & BIT_TICK & ~rx_in & ~st_reg.low_seen
                         & (st_reg.low_cnt == sbe_cnt_t'(LIN_DET_LEN - CNT_ONE));

  always_comb
  begin
    // break length by select and character format
    if (LONG_BREAK_SELECT)
      brk_len = NINE_BIT_SELECT ? BRK_LONG_M : BRK_LONG_LEN;
    else
      brk_len = NINE_BIT_SELECT ? BRK_SHORT_M : BRK_SHORT_LEN;
  end

  always_comb
  begin
    st_next         = st_reg;
    st_next.rx_prev = rx_in;
    st_next.rx_data = rx_in;

    // set wins over a write-one clear; zero writes do nothing
    if (active_edge)
      st_next.rx_edge_flag = 1'b1;
    else if (RX_EDGE_FLAG_WR && FLAG_WR_DATA)
      st_next.rx_edge_flag = 1'b0;

    // consecutive low bit-time counter, saturating at threshold
    if (rx_in)
    begin
      st_next.low_cnt  = CNT_ZERO;
      st_next.low_seen = 1'b0;
    end
    else if (BIT_TICK && st_reg.low_cnt != LIN_DET_LEN)
      st_next.low_cnt = st_reg.low_cnt + CNT_ONE;
    if (lin_break_hit)
      st_next.low_seen = 1'b1;

    if (lin_break_hit)
      st_next.lin_break_flag = 1'b1;
    else if (LIN_BREAK_FLAG_WR && FLAG_WR_DATA)
      st_next.lin_break_flag = 1'b0;

    // framing check ignores break length select
    st_next.fe_set   = FRAME_ERR_EVENT & ~LIN_BREAK_DETECT_ENABLE;
    st_next.full_set = RX_FULL_EVENT & ~LIN_BREAK_DETECT_ENABLE;
    st_next.idle_set = IDLE_EVENT & (~RECEIVER_STANDBY | STANDBY_IDLE_FLAG_SELECT);

    case (st_reg.tx_state)
      SBE_TX_IDLE:
      begin
        st_next.txd = LINE_IDLE;
        if (BREAK_SEND_REQ)
        begin
          st_next.tx_state = SBE_TX_BRK;
          st_next.tx_cnt   = CNT_ZERO;
          st_next.tx_len   = brk_len;
          st_next.txd      = ~LINE_IDLE;
        end
      end
      SBE_TX_BRK:
      begin
        if (BIT_TICK)
        begin
          if (st_reg.tx_cnt == st_reg.tx_len - CNT_ONE)
          begin
            st_next.tx_state = SBE_TX_IDLE;
            st_next.txd      = LINE_IDLE;
          end
          else
            st_next.tx_cnt = st_reg.tx_cnt + CNT_ONE;
        end
      end
      default:
      begin
        st_next.tx_state = SBE_TX_IDLE;
        st_next.txd      = LINE_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      st_reg                <= '0;
      st_reg.rx_prev        <= LINE_IDLE;
      st_reg.rx_data        <= LINE_IDLE;
      st_reg.tx_state       <= SBE_TX_IDLE;
      st_reg.txd            <= LINE_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign RX_DATA           = st_reg.rx_data;
  assign RX_EDGE_FLAG      = st_reg.rx_edge_flag;
  assign LIN_BREAK_FLAG    = st_reg.lin_break_flag;
  assign FRAMING_ERROR_SET = st_reg.fe_set;
  assign RX_FULL_SET       = st_reg.full_set;
  assign IDLE_SET          = st_reg.idle_set;
  assign TX_LINE           = st_reg.txd;
  assign BREAK_BUSY        = (st_reg.tx_state == SBE_TX_BRK);

  AST_EDGE_SETS: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !RX_EDGE_FLAG && !active_edge |=> !RX_EDGE_FLAG)
    else $error("edge flag set without active edge");
  AST_EDGE_FLAG: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $fell(RXD_PIN ^ RX_INVERT) && !$changed(RX_INVERT) |=> RX_EDGE_FLAG)
    else $error("active edge did not set edge flag");
  AST_EDGE_CLR: assert property (@(posedge CORE_CLK) disable iff (SRST)
    RX_EDGE_FLAG_WR && FLAG_WR_DATA && !active_edge |=> !RX_EDGE_FLAG)
    else $error("edge flag not cleared by write one");
  AST_ZERO_WR_KEEPS: assert property (@(posedge CORE_CLK) disable iff (SRST)
    LIN_BREAK_FLAG && !(LIN_BREAK_FLAG_WR && FLAG_WR_DATA) |=> LIN_BREAK_FLAG)
    else $error("break flag lost without write one");
  AST_INVERT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    1'b1 |=> RX_DATA == ($past(RXD_PIN) ^ $past(RX_INVERT)))
    else $error("receive data polarity wrong");
  AST_IDLE_STBY: assert property (@(posedge CORE_CLK) disable iff (SRST)
    IDLE_EVENT && RECEIVER_STANDBY && !STANDBY_IDLE_FLAG_SELECT |=> !IDLE_SET)
    else $error("idle flagged in standby without select");
  AST_BRK_LEN: assert property (@(posedge CORE_CLK) disable iff (SRST)
    BREAK_SEND_REQ && !BREAK_BUSY |=> st_reg.tx_len == $past(brk_len) && !TX_LINE)
    else $error("break length or start wrong");
  AST_SUPPRESS: assert property (@(posedge CORE_CLK) disable iff (SRST)
    LIN_BREAK_DETECT_ENABLE |=> !FRAMING_ERROR_SET && !RX_FULL_SET)
    else $error("flags set while LIN detect enabled");
  AST_LIN_BRK: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $rose(LIN_BREAK_FLAG) |-> $past(st_reg.low_cnt) == sbe_cnt_t'(LIN_DET_LEN - CNT_ONE)
    && $past(LIN_BREAK_DETECT_ENABLE))
    else $error("break flag set before threshold");
endmodule

// ### testbench/sbe_node.sv
/*
  LIN node model: gives the bit-time tick and adds a dominant low to the line.
  Assumes one clock; the line is the wired-and of block and node, recessive high.
*/
`timescale 1ns/10ps
module sbe_node
(
  input  wire logic CORE_CLK,
  input  wire logic TX_LINE,
  input  wire logic NODE_LOW,
  output logic      LINE,
  output logic      BIT_TICK
);
  logic [1:0] div_reg = 2'h0;

  // one bit time is four clocks
  always @(posedge CORE_CLK)
    div_reg <= div_reg + 2'h1;

  assign BIT_TICK = (div_reg == 2'h3);
  // dominant low wins, recessive high
  assign LINE     = TX_LINE & ~NODE_LOW;
endmodule

// ### testbench/testbench.sv
/*
  Self-checking bench for sbe_ctrl: one task per scenario drives the block through
  the node model and judges flags, receive data and the break line before it returns.
  Assumes sbe_pkg compiled first; the node model makes the bit tick and the line.
*/
`timescale 1ns/10ps
`define CHK(n, e, s) \
  begin \
    cmp_count++; \
    if ((s) !== (e)) \
    begin \
      miscompares++; \
      $display("unexpected %s exp %0d got %0d", n, e, s); \
    end \
  end

module testbench;
  import sbe_pkg::*;

  // scenarios take a few hundred cycles
  localparam int TIMEOUT_CYC = 4000;

  logic clk;
  logic srst        = 1'b1;
  logic inv         = 1'b0;
  logic stby        = 1'b0;
  logic sel         = 1'b0;
  logic lng         = 1'b0;
  logic nine        = 1'b0;
  logic lin         = 1'b0;
  logic ewr         = 1'b0;
  logic lwr         = 1'b0;
  logic wd          = 1'b0;
  logic fev         = 1'b0;
  logic rev         = 1'b0;
  logic iev         = 1'b0;
  logic req         = 1'b0;
  logic nlow        = 1'b0;
  logic line;
  logic tick;
  logic rxd;
  logic eflag;
  logic lflag;
  logic fe;
  logic full;
  logic idle;
  logic txd;
  logic busy;
  int   miscompares = 0;
  int   cmp_count   = 0;
  int   cyc         = 0;

  sbe_ctrl i_sbe_ctrl
  (
    .CORE_CLK                 (clk),
    .SRST                     (srst),
    .RXD_PIN                  (line),
    .BIT_TICK                 (tick),
    .RX_INVERT                (inv),
    .RECEIVER_STANDBY         (stby),
    .STANDBY_IDLE_FLAG_SELECT (sel),
    .LONG_BREAK_SELECT        (lng),
    .NINE_BIT_SELECT          (nine),
    .LIN_BREAK_DETECT_ENABLE  (lin),
    .RX_EDGE_FLAG_WR          (ewr),
    .LIN_BREAK_FLAG_WR        (lwr),
    .FLAG_WR_DATA             (wd),
    .FRAME_ERR_EVENT          (fev),
    .RX_FULL_EVENT            (rev),
    .IDLE_EVENT               (iev),
    .BREAK_SEND_REQ           (req),
    .RX_DATA                  (rxd),
    .RX_EDGE_FLAG             (eflag),
    .LIN_BREAK_FLAG           (lflag),
    .FRAMING_ERROR_SET        (fe),
    .RX_FULL_SET              (full),
    .IDLE_SET                 (idle),
    .TX_LINE                  (txd),
    .BREAK_BUSY               (busy)
  );

  sbe_node i_sbe_node
  (
    .CORE_CLK (clk),
    .TX_LINE  (txd),
    .NODE_LOW (nlow),
    .LINE     (line),
    .BIT_TICK (tick)
  );

  initial
  begin
    clk = 1'b0;
    forever
      #20 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == TIMEOUT_CYC)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic step(input int n);
    repeat (n)
      @(posedge clk);
    #1;
  endtask

  // one-cycle write strobe; lin_sel picks the LIN break flag
  task automatic wr(input logic lin_sel, input logic d);
    if (lin_sel)
      lwr = 1'b1;
    else
      ewr = 1'b1;
    wd = d;
    step(1);
    ewr = 1'b0;
    lwr = 1'b0;
  endtask

  task automatic t_edge();
    nlow = 1'b1;
    step(2);
    `CHK("rx data", 1'b0, rxd)
    `CHK("edge fall", 1'b1, eflag)
    wr(1'b0, 1'b0);
    step(1);
    `CHK("edge wr0", 1'b1, eflag)
    wr(1'b0, 1'b1);
    step(1);
    `CHK("edge clr", 1'b0, eflag)
    inv = 1'b1;
    step(2);
    `CHK("rx inv", 1'b1, rxd)
    nlow = 1'b0;
    step(2);
    `CHK("edge rise", 1'b1, eflag)
    inv = 1'b0;
    step(2);
    wr(1'b0, 1'b1);
    step(1);
    // edge and clear in one cycle: the set wins
    nlow = 1'b1;
    wr(1'b0, 1'b1);
    step(1);
    `CHK("edge set wins", 1'b1, eflag)
    nlow = 1'b0;
    wr(1'b0, 1'b1);
    step(1);
  endtask

  task automatic t_break();
    int n;
    int c;
    for (int i = 0; i < 4; i++)
    begin
      {lng, nine} = i[1:0];
      n = 0;
      c = 0;
      req = 1'b1;
      step(1);
      req = 1'b0;
      while (busy === 1'b1 && c < 100)
      begin
        `CHK("break low", 1'b0, txd)
        if (tick)
          n++;
        // a request in mid-break must be ignored
        req = (c == 5);
        c++;
        step(1);
      end
      `CHK("break end", 1'b1, txd)
      `CHK("break len", (i > 1 ? 13 : 10) + i % 2, n)
    end
    wr(1'b0, 1'b1);
  endtask

  // holds the line low for exactly n ticks seen by the block
  task automatic low_ticks(input int n);
    while (tick !== 1'b1)
      step(1);
    step(1);
    nlow = 1'b1;
    while (n > 0)
    begin
      if (tick)
        n--;
      step(1);
    end
    nlow = 1'b0;
    step(3);
  endtask

  task automatic t_lin();
    lin = 1'b1;
    low_ticks(10);
    `CHK("lin 10", 1'b0, lflag)
    low_ticks(11);
    `CHK("lin 11", 1'b1, lflag)
    wr(1'b1, 1'b0);
    step(1);
    `CHK("lin wr0", 1'b1, lflag)
    wr(1'b1, 1'b1);
    step(1);
    `CHK("lin clr", 1'b0, lflag)
    for (int i = 0; i < 4; i++)
    begin
      {lin, lng} = i[1:0];
      fev = 1'b1;
      rev = 1'b1;
      step(1);
      fev = 1'b0;
      rev = 1'b0;
      `CHK("fe set", ~lin, fe)
      `CHK("full set", ~lin, full)
    end
  endtask

  task automatic t_idle();
    for (int i = 0; i < 4; i++)
    begin
      {stby, sel} = i[1:0];
      iev = 1'b1;
      step(1);
      iev = 1'b0;
      `CHK("idle set", !(i == 2), idle)
    end
  endtask

  initial
  begin
    step(8);
    srst = 1'b0;
    step(1);
    `CHK("reset flags", 2'b00, {eflag, lflag})
    `CHK("reset line", 2'b10, {txd, busy})
    t_edge();
    t_break();
    t_lin();
    t_idle();
    wrap_up();
  end
endmodule
